// >>> verilog/add_and_compare_branch_exec.sv
`timescale 1ns/1ps
module add_and_compare_branch_exec
    import exec_slice_pkg::*;
(
    // Clock and reset
    input  wire logic                   i_ref_clk,
    input  wire logic                   i_rst_n,
    // Instruction from the decoder
    input  wire logic                   i_valid,
    input  wire instr_t                 i_instr,
    input  wire operands_t              i_opnd,
    // Initial state loads
    input  wire logic                   i_load,
    input  wire logic [BYTE_W-1:0]      i_load_acc,
    input  wire flags_t                 i_load_flags,
    input  wire logic [PTR_W-1:0]       i_load_ip,
    // Architectural state
    output logic      [BYTE_W-1:0]      o_acc,
    output flags_t                      o_flags,
    output logic      [PTR_W-1:0]       o_ip,
    // Direct byte write-back
    output logic                        o_direct_we,
    output logic      [BYTE_W-1:0]      o_direct_addr,
    output logic      [BYTE_W-1:0]      o_direct_data,
    // Executed strobe
    output logic                        o_done
);

    // Combinational result of the current instruction
    logic [BYTE_W-1:0] src_byte;
    logic [BYTE_W-1:0] dir_orig;
    logic [BYTE_W-1:0] cmp_first;
    logic [BYTE_W-1:0] cmp_second;
    logic [BYTE_W-1:0] sum;
    logic              cout;
    logic              half;
    logic              ovf;
    logic              cin;
    logic [BYTE_W-1:0] acc_d;
    flags_t            flags_d;
    logic [PTR_W-1:0]  ip_d;
    logic [PTR_W-1:0]  ip_adv;
    logic              dwe_d;
    logic [BYTE_W-1:0] ddata_d;

    // Source operand selection by addressing mode
    function automatic logic [BYTE_W-1:0] pick_src(input src_mode_t m, input instr_t ins,
                                                   input operands_t o);
        case (m)
            SRC_WORKING_REG: pick_src = o.reg_val;
            SRC_DIRECT:      pick_src = o.direct_val;
            SRC_INDIRECT:    pick_src = o.indirect_val;
            SRC_IMMEDIATE:   pick_src = ins.byte2;
            default:         pick_src = ins.byte2;
        endcase
    endfunction : pick_src

    // Carry-in only for the carry form
    assign cin = (i_instr.op == OP_BYTE_SUM_CARRY) ? o_flags.carry : 1'b0;

    byte_adder #(
        .WIDTH (BYTE_W)
    ) u_adder (
        .i_a    (o_acc),
        .i_b    (src_byte),
        .i_cin  (cin),
        .o_sum  (sum),
        .o_cout (cout),
        .o_half (half),
        .o_ovf  (ovf)
    );

    // Operand, result and flag computation
    always_comb begin
        src_byte   = pick_src(i_instr.mode, i_instr, i_opnd);
        // Port targets read back the output latch
        dir_orig   = i_opnd.direct_is_port ? i_opnd.direct_latch : i_opnd.direct_val;
        cmp_first  = o_acc;
        cmp_second = i_instr.byte2;
        acc_d      = o_acc;
        flags_d    = o_flags;
        ip_d       = o_ip;
        ip_adv     = o_ip;
        dwe_d      = 1'b0;
        ddata_d    = 8'h00;
        case (i_instr.op)
            OP_BYTE_SUM, OP_BYTE_SUM_CARRY: begin
                acc_d                        = sum;
                flags_d.carry                = cout;
                flags_d.half_carry_flag      = half;
                flags_d.signed_overflow_flag = ovf;
            end
            OP_PAGE_JUMP: begin
                ip_adv = o_ip + JUMP_LEN;
                ip_d   = {ip_adv[PTR_W-1:PAGE_LOW_W],
                          i_instr.opcode[OPC_PAGE_HI:OPC_PAGE_LO], i_instr.byte2};
            end
            OP_AND_ACC: begin
                acc_d = o_acc & src_byte;
            end
            OP_AND_DIRECT: begin
                // Mode immediate masks with byte3, otherwise with the accumulator
                dwe_d   = 1'b1;
                ddata_d = dir_orig & ((i_instr.mode == SRC_IMMEDIATE) ? i_instr.byte3
                                                                      : o_acc);
            end
            OP_AND_BIT: begin
                flags_d.carry = o_flags.carry & i_opnd.bit_val;
            end
            OP_AND_NOT_BIT: begin
                flags_d.carry = o_flags.carry & ~i_opnd.bit_val;
            end
            OP_CMP_BRANCH: begin
                // Direct or immediate against the accumulator, else reg/indirect vs imm
                case (i_instr.mode)
                    SRC_DIRECT: begin
                        cmp_first  = o_acc;
                        cmp_second = i_opnd.direct_val;
                    end
                    SRC_IMMEDIATE: begin
                        cmp_first  = o_acc;
                        cmp_second = i_instr.byte2;
                    end
                    SRC_INDIRECT: begin
                        cmp_first  = i_opnd.indirect_val;
                        cmp_second = i_instr.byte2;
                    end
                    default: begin
                        cmp_first  = i_opnd.reg_val;
                        cmp_second = i_instr.byte2;
                    end
                endcase
                ip_adv        = o_ip + BRANCH_LEN;
                ip_d          = (cmp_first != cmp_second)
                              ? ip_adv + {{(PTR_W-BYTE_W){i_instr.byte3[SIGN_BIT]}}, i_instr.byte3}
                              : ip_adv;
                flags_d.carry = (cmp_first < cmp_second);
            end
            default: begin
                acc_d = o_acc;
            end
        endcase
    end

    // Accumulator, flags and pointer
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_acc   <= ACC_RST;
            o_flags <= '0;
            o_ip    <= IP_RST;
        end else if (i_load) begin
            o_acc   <= i_load_acc;
            o_flags <= i_load_flags;
            o_ip    <= i_load_ip;
        end else if (i_valid) begin
            o_acc   <= acc_d;
            o_flags <= flags_d;
            o_ip    <= ip_d;
        end
    end

    // Direct write-back and done strobe, one cycle per instruction
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_direct_we   <= 1'b0;
            o_direct_addr <= 8'h00;
            o_direct_data <= 8'h00;
            o_done        <= 1'b0;
        end else begin
            o_direct_we   <= i_valid && !i_load && dwe_d;
            o_direct_addr <= i_instr.byte2;
            o_direct_data <= ddata_d;
            o_done        <= i_valid && !i_load;
        end
    end

    // Assertions
    property p_add_flags;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_valid && !i_load && i_instr.op == OP_BYTE_SUM)
        |=> o_acc == $past(o_acc + src_byte)
            && o_flags.carry == $past(({1'b0, o_acc} + {1'b0, src_byte}) > 9'h0ff);
    endproperty
    a_add_flags: assert property (p_add_flags) else $error("add result wrong");

    property p_ovf;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_valid && !i_load && i_instr.op == OP_BYTE_SUM)
        |=> o_flags.signed_overflow_flag == $past((o_acc[7] == src_byte[7])
                                                   && (sum[7] != o_acc[7]));
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow flag wrong");

    property p_byte_sum_carry_op;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_valid && !i_load && i_instr.op == OP_BYTE_SUM_CARRY)
        |=> o_acc == $past(o_acc + src_byte + {7'h00, o_flags.carry});
    endproperty
    a_byte_sum_carry_op: assert property (p_byte_sum_carry_op) else $error("add with carry wrong");

    property p_done;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_valid && !i_load) |=> o_done;
    endproperty
    a_done: assert property (p_done) else $error("done missing");

    property p_jump;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_valid && !i_load && i_instr.op == OP_PAGE_JUMP)
        |=> o_ip[7:0] == $past(i_instr.byte2) && o_ip[10:8] == $past(i_instr.opcode[7:5]);
    endproperty
    a_jump: assert property (p_jump) else $error("page jump target wrong");

    property p_and_flags;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_valid && !i_load && (i_instr.op == OP_AND_ACC || i_instr.op == OP_AND_DIRECT))
        |=> $stable(o_flags);
    endproperty
    a_and_flags: assert property (p_and_flags) else $error("AND changed flags");

    property p_and_bit;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_valid && !i_load && i_instr.op == OP_AND_BIT && !i_opnd.bit_val)
        |=> !o_flags.carry && $stable(o_flags.half_carry_flag);
    endproperty
    a_and_bit: assert property (p_and_bit) else $error("bit AND carry wrong");

    property p_and_not_bit;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_valid && !i_load && i_instr.op == OP_AND_NOT_BIT && i_opnd.bit_val)
        |=> !o_flags.carry && $stable(o_flags.half_carry_flag)
            && $stable(o_flags.signed_overflow_flag) && $stable(o_acc);
    endproperty
    a_and_not_bit: assert property (p_and_not_bit) else $error("inverted bit AND wrong");

    property p_port_latch;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_valid && !i_load && i_instr.op == OP_AND_DIRECT && i_opnd.direct_is_port
         && i_instr.mode == SRC_IMMEDIATE)
        |=> o_direct_we && o_direct_data == $past(i_opnd.direct_latch & i_instr.byte3);
    endproperty
    a_port_latch: assert property (p_port_latch) else $error("port AND read the pins");

    property p_cmp;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_valid && !i_load && i_instr.op == OP_CMP_BRANCH)
        |=> o_flags.carry == $past(cmp_first < cmp_second) && $stable(o_acc);
    endproperty
    a_cmp: assert property (p_cmp) else $error("compare carry wrong");

    property p_cmp_eq;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_valid && !i_load && i_instr.op == OP_CMP_BRANCH && cmp_first == cmp_second)
        |=> o_ip == $past(o_ip) + 16'h0003;
    endproperty
    a_cmp_eq: assert property (p_cmp_eq) else $error("equal branch taken");

endmodule : add_and_compare_branch_exec

// >>> verilog/exec_slice_pkg.sv
package exec_slice_pkg;

    // Opcode classes handled by this slice
    typedef enum logic [3:0] {
        OP_NONE,
        OP_BYTE_SUM,
        OP_BYTE_SUM_CARRY,
        OP_PAGE_JUMP,
        OP_AND_ACC,
        OP_AND_DIRECT,
        OP_AND_BIT,
        OP_AND_NOT_BIT,
        OP_CMP_BRANCH
    } exec_op_t;

    // Source and first-operand modes
    typedef enum logic [1:0] {
        SRC_WORKING_REG,
        SRC_DIRECT,
        SRC_INDIRECT,
        SRC_IMMEDIATE
    } src_mode_t;

    // Widths and field positions
    localparam int BYTE_W        = 8;
    localparam int PTR_W         = 16;
    localparam int PAGE_LOW_W    = 11;
    localparam int HALF_BIT      = 3;
    localparam int SIGN_BIT      = 7;
    localparam int OPC_PAGE_HI   = 7;
    localparam int OPC_PAGE_LO   = 5;
    localparam logic [PTR_W-1:0] JUMP_LEN   = 16'h0002;
    localparam logic [PTR_W-1:0] BRANCH_LEN = 16'h0003;

    // Reset values
    localparam logic [BYTE_W-1:0] ACC_RST = 8'h00;
    localparam logic [PTR_W-1:0]  IP_RST  = 16'h0000;

    // Decoded instruction as handed over by the decoder
    typedef struct packed {
        exec_op_t           op;
        src_mode_t          mode;
        logic [BYTE_W-1:0]  opcode;
        logic [BYTE_W-1:0]  byte2;
        logic [BYTE_W-1:0]  byte3;
    } instr_t;

    // Operand values fetched for the instruction
    typedef struct packed {
        logic [BYTE_W-1:0] reg_val;
        logic [BYTE_W-1:0] direct_val;
        logic [BYTE_W-1:0] direct_latch;
        logic              direct_is_port;
        logic [BYTE_W-1:0] indirect_val;
        logic              bit_val;
    } operands_t;

    // Processor flags
    typedef struct packed {
        logic carry;
        logic half_carry_flag;
        logic signed_overflow_flag;
    } flags_t;

endpackage : exec_slice_pkg

// >>> verilog/byte_adder.sv
`timescale 1ns/1ps
// Byte adder with the three addition flags
module byte_adder
    import exec_slice_pkg::*;
#(
    parameter int WIDTH = BYTE_W
) (
    // Operands
    input  wire logic [WIDTH-1:0] i_a,
    input  wire logic [WIDTH-1:0] i_b,
    input  wire logic             i_cin,
    // Results
    output logic      [WIDTH-1:0] o_sum,
    output logic                  o_cout,
    output logic                  o_half,
    output logic                  o_ovf
);
    // Carries are tapped at fixed bit positions, so only the byte width is served
    if (WIDTH != BYTE_W) begin : g_width_check
        $error("byte_adder: WIDTH must be %0d", BYTE_W);
    end

    logic [4:0] low_sum;
    logic [7:0] low7_sum;
    logic [8:0] full_sum;

    // Partial sums expose carries out of bits 3 and 6
    always_comb begin
        low_sum  = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]} + {4'h0, i_cin};
        low7_sum = {1'b0, i_a[6:0]} + {1'b0, i_b[6:0]} + {7'h00, i_cin};
        full_sum = {1'b0, i_a} + {1'b0, i_b} + {8'h00, i_cin};
        o_sum    = full_sum[7:0];
        o_cout   = full_sum[8];
        o_half   = low_sum[4];
        o_ovf    = low7_sum[7] ^ full_sum[8];
    end
endmodule : byte_adder

// >>> bench/exec_partner_model.sv
`timescale 1ns/1ps
// Far side: operand fetch from data memory, working registers and port latch
module exec_partner_model
    import exec_slice_pkg::*;
(
    // Clock
    input  wire logic              i_ref_clk,
    // Instruction and write-back from the slice
    input  wire instr_t            i_instr,
    input  wire logic              i_direct_we,
    input  wire logic [BYTE_W-1:0] i_direct_addr,
    input  wire logic [BYTE_W-1:0] i_direct_data,
    // Levels seen on the port pins
    input  wire logic [BYTE_W-1:0] i_pins,
    // Fetched operands
    output operands_t              o_opnd
);
    localparam logic [BYTE_W-1:0] PORT_ADDR = 8'h90;
    logic [BYTE_W-1:0] mem [256];
    logic [BYTE_W-1:0] bit_byte;
    logic              is_port;

    // Each byte holds its inverted address; working regs 0 and 1 point at 40h and 41h
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = ~8'(i);
        end
        mem[0] = 8'h40;
        mem[1] = 8'h41;
    end

    // Write-back lands one edge after the slice offers it
    always @(posedge i_ref_clk) begin
        if (i_direct_we) begin
            mem[i_direct_addr] <= i_direct_data;
        end
    end

    // Pins differ from the latch, so a wrong source shows at once
    assign is_port  = (i_instr.byte2 == PORT_ADDR);
    assign bit_byte = mem[8'h20 + {4'h0, i_instr.byte2[6:3]}];
    assign o_opnd = '{
        reg_val:        mem[{5'h0, i_instr.opcode[2:0]}],
        direct_val:     is_port ? i_pins : mem[i_instr.byte2],
        direct_latch:   mem[i_instr.byte2],
        direct_is_port: is_port,
        indirect_val:   mem[mem[{7'h0, i_instr.opcode[0]}]],
        bit_val:        bit_byte[i_instr.byte2[2:0]]
    };
endmodule : exec_partner_model

// >>> bench/add_and_compare_branch_exec_tb_top.sv
`timescale 1ns/1ps
// Self-checking bench for the add, AND and compare-branch slice
module add_and_compare_branch_exec_tb_top
    import exec_slice_pkg::*;
();
    // One row: start state, instruction, expected state
    typedef struct packed {
        exec_op_t   op;
        src_mode_t  md;
        logic [7:0] opc, b2, b3, acc;
        logic [2:0] fl;
        logic [15:0] ip;
        logic [7:0] eacc;
        logic [2:0] efl;
        logic [15:0] eip;
    } row_t;

    localparam exec_op_t SUM = OP_BYTE_SUM, SUMC = OP_BYTE_SUM_CARRY, JMP = OP_PAGE_JUMP;
    localparam exec_op_t ANDA = OP_AND_ACC, ANDD = OP_AND_DIRECT, ANDB = OP_AND_BIT;
    localparam exec_op_t ANDN = OP_AND_NOT_BIT, CMP = OP_CMP_BRANCH, NOP = OP_NONE;
    localparam src_mode_t REG = SRC_WORKING_REG, DIR = SRC_DIRECT, IND = SRC_INDIRECT;
    localparam src_mode_t IMM = SRC_IMMEDIATE;

    // Flags are {carry, half, overflow}; on direct-write rows eip holds the write data
    localparam row_t ROWS [23] = '{
        '{SUM,  IMM, 8'h24, 8'haa, 8'h00, 8'hc3, 3'h0, 16'h0100, 8'h6d, 3'h5, 16'h0100},
        '{SUMC, IMM, 8'h34, 8'haa, 8'h00, 8'hc3, 3'h4, 16'h0100, 8'h6e, 3'h5, 16'h0100},
        '{SUM,  REG, 8'h2a, 8'h00, 8'h00, 8'h03, 3'h0, 16'h0100, 8'h00, 3'h6, 16'h0100},
        '{SUM,  DIR, 8'h25, 8'h7f, 8'h00, 8'h80, 3'h2, 16'h0100, 8'h00, 3'h5, 16'h0100},
        '{SUM,  IND, 8'h27, 8'h00, 8'h00, 8'h01, 3'h7, 16'h0100, 8'hbf, 3'h0, 16'h0100},
        '{SUMC, IND, 8'h36, 8'h00, 8'h00, 8'h40, 3'h4, 16'h0100, 8'h00, 3'h6, 16'h0100},
        '{SUMC, DIR, 8'h35, 8'hbf, 8'h00, 8'h3f, 3'h4, 16'h0100, 8'h80, 3'h3, 16'h0100},
        '{SUMC, REG, 8'h3f, 8'h00, 8'h00, 8'h70, 3'h1, 16'h0100, 8'h68, 3'h4, 16'h0100},
        '{ANDA, REG, 8'h5b, 8'h00, 8'h00, 8'hc3, 3'h7, 16'h0100, 8'hc0, 3'h7, 16'h0100},
        '{ANDA, IMM, 8'h54, 8'h55, 8'h00, 8'hc3, 3'h2, 16'h0100, 8'h41, 3'h2, 16'h0100},
        '{ANDA, IND, 8'h57, 8'h00, 8'h00, 8'hff, 3'h5, 16'h0100, 8'hbe, 3'h5, 16'h0100},
        '{ANDA, DIR, 8'h55, 8'h33, 8'h00, 8'h0f, 3'h3, 16'h0100, 8'h0c, 3'h3, 16'h0100},
        '{ANDD, DIR, 8'h52, 8'h90, 8'h00, 8'h3c, 3'h1, 16'h0100, 8'h3c, 3'h1, 16'h002c},
        '{ANDD, IMM, 8'h53, 8'h90, 8'h0f, 8'h5a, 3'h6, 16'h0100, 8'h5a, 3'h6, 16'h000c},
        '{ANDB, DIR, 8'h82, 8'h05, 8'h00, 8'h00, 3'h7, 16'h0100, 8'h00, 3'h3, 16'h0100},
        '{ANDB, DIR, 8'h82, 8'h00, 8'h00, 8'h00, 3'h5, 16'h0100, 8'h00, 3'h5, 16'h0100},
        '{ANDN, DIR, 8'hb0, 8'h00, 8'h00, 8'h00, 3'h7, 16'h0100, 8'h00, 3'h3, 16'h0100},
        '{JMP,  IMM, 8'ha1, 8'h23, 8'h00, 8'h00, 3'h0, 16'h07fe, 8'h00, 3'h0, 16'h0d23},
        '{CMP,  IMM, 8'hb4, 8'h60, 8'h10, 8'h34, 3'h2, 16'h0100, 8'h34, 3'h6, 16'h0113},
        '{CMP,  DIR, 8'hb5, 8'hcb, 8'h80, 8'h34, 3'h5, 16'h0200, 8'h34, 3'h1, 16'h0203},
        '{CMP,  REG, 8'hbf, 8'h60, 8'hfe, 8'h00, 3'h4, 16'h0300, 8'h00, 3'h0, 16'h0301},
        '{CMP,  IND, 8'hb6, 8'hc0, 8'h80, 8'h00, 3'h0, 16'h0010, 8'h00, 3'h4, 16'hff93},
        '{NOP,  IMM, 8'h00, 8'h00, 8'h00, 8'h5a, 3'h7, 16'h1234, 8'h5a, 3'h7, 16'h1234}
    };

    logic              i_ref_clk = 1'b0;
    logic              i_rst_n, i_valid, i_load, o_direct_we, o_done;
    instr_t            i_instr;
    operands_t         i_opnd;
    flags_t            i_load_flags, o_flags;
    logic [BYTE_W-1:0] i_load_acc, o_acc, o_direct_addr, o_direct_data;
    logic [BYTE_W-1:0] pins = 8'hf0;
    logic [PTR_W-1:0]  i_load_ip, o_ip;
    int                miscompares = 0;
    int                cmp_count = 0;

    always #2 i_ref_clk = ~i_ref_clk;

    add_and_compare_branch_exec u_add_and_compare_branch_exec (
        .i_ref_clk, .i_rst_n, .i_valid, .i_instr, .i_opnd, .i_load, .i_load_acc,
        .i_load_flags, .i_load_ip, .o_acc, .o_flags, .o_ip, .o_direct_we,
        .o_direct_addr, .o_direct_data, .o_done
    );

    exec_partner_model u_exec_partner_model (
        .i_ref_clk, .i_instr, .i_direct_we(o_direct_we), .i_direct_addr(o_direct_addr),
        .i_direct_data(o_direct_data), .i_pins(pins), .o_opnd(i_opnd)
    );

    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_of_test

    // Load the start state, then offer one instruction; returns just after it is taken
    task automatic issue(input row_t r);
        @(posedge i_ref_clk);
        i_load       <= 1'b1;
        i_load_acc   <= r.acc;
        i_load_flags <= flags_t'(r.fl);
        i_load_ip    <= r.ip;
        @(posedge i_ref_clk);
        i_load  <= 1'b0;
        i_valid <= 1'b1;
        i_instr <= '{r.op, r.md, r.opc, r.b2, r.b3};
        @(posedge i_ref_clk);
        i_valid <= 1'b0;
        #1;
    endtask : issue

    initial begin
        row_t r;
        i_rst_n      = 1'b0;
        i_valid      = 1'b0;
        i_load       = 1'b0;
        i_instr      = '0;
        i_load_acc   = 8'h00;
        i_load_flags = '0;
        i_load_ip    = 16'h0000;
        repeat (6) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        // Table of ordinary cases
        foreach (ROWS[i]) begin
            r = ROWS[i];
            issue(r);
            check(24'(o_done), 24'h1);
            check(24'(o_acc), 24'(r.eacc));
            check(24'(o_flags), 24'(r.efl));
            if (r.op != ANDD) begin
                check(24'(o_ip), 24'(r.eip));
            end
            check(24'(o_direct_we), 24'(r.op == ANDD));
            if (r.op == ANDD) begin
                check(24'({o_direct_addr, o_direct_data}), 24'({r.b2, r.eip[7:0]}));
            end
        end
        // Back-to-back adds; the second must use the carry left by the first
        issue('{NOP, IMM, 8'h00, 8'h00, 8'h00, 8'hff, 3'h0, 16'h0, 8'hff, 3'h0, 16'h0});
        @(posedge i_ref_clk);
        i_valid <= 1'b1;
        i_instr <= '{SUM, IMM, 8'h24, 8'h01, 8'h00};
        @(posedge i_ref_clk);
        i_instr <= '{SUMC, IMM, 8'h34, 8'h00, 8'h00};
        #1 check(24'({o_acc, o_flags}), 24'h000006);
        @(posedge i_ref_clk);
        i_valid <= 1'b0;
        #1 check(24'({o_acc, o_flags, o_done}), 24'h000011);
        // A load offered with an instruction wins and drops it
        @(posedge i_ref_clk);
        i_valid    <= 1'b1;
        i_load     <= 1'b1;
        i_load_acc <= 8'h99;
        i_load_ip  <= 16'h0abc;
        @(posedge i_ref_clk);
        i_valid <= 1'b0;
        i_load  <= 1'b0;
        #1 check(24'({o_acc, o_done}), 24'h000132);
        // Reset in mid-run with an add offered clears all state
        @(posedge i_ref_clk);
        i_rst_n <= 1'b0;
        i_valid <= 1'b1;
        repeat (2) @(posedge i_ref_clk);
        #1 check(24'({o_acc, o_flags, o_direct_we, o_done}), 24'h0);
        check(24'(o_ip), 24'h0);
        @(posedge i_ref_clk);
        // First instruction at the first edge after release must execute normally
        i_rst_n <= 1'b1;
        i_instr <= '{SUM, IMM, 8'h24, 8'h05, 8'h00};
        @(posedge i_ref_clk);
        i_valid <= 1'b0;
        #1 check(24'({o_acc, o_flags, o_done}), 24'h000051);
        end_of_test();
    end

    // Hang guard; the whole sequence needs about 90 cycles
    initial begin
        repeat (2000) @(posedge i_ref_clk);
        miscompares++;
        end_of_test();
    end
endmodule : add_and_compare_branch_exec_tb_top
